// File: design/pcisb_top.sv
// PCI sideband control: errors, arbitration, lock, reset and wake
// How it works
// - Drive parity error line on own errors
// - Parity errors raise NMI or management interrupt
// - Arbitrate seven masters, one request/grant each
// - Requests four to six usable as inputs
// - Grant four usable as general output
// - Latch grant six at power-good rise
// - Everything timed from one bus clock
// - Secondary reset is platform reset OR bit
// - Assert lock during own locked sequences
// - Ignore lock while external master granted
// - System error raises NMI, management or interrupt
// - Wake event wakes system from S1-S5
// - Enabled wake event in S0 raises control interrupt
// - Drive wake line on internal wake
// - Never drive wake line high
// - Even parity over all 36 bits
// - Check parity when target of writes
//
// The register addresses and the APB register port were decided locally.
module pcisb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [pcisb_pkg::NMASTERS-1:0] req_n,
  output logic [pcisb_pkg::NMASTERS-1:0] gnt_n,
  input wire logic gnt6_pin_i,
  input wire logic power_good,
  input wire logic platform_reset_n,
  output logic secondary_bus_reset_n,
  input wire logic [pcisb_pkg::AD_W-1:0] ad_i,
  input wire logic [pcisb_pkg::CBE_W-1:0] cbe_n_i,
  input wire logic par_i,
  input wire logic tgt_write_phase,
  input wire logic drive_phase,
  output logic par_o,
  output logic par_oe,
  input wire logic perr_n_i,
  output logic perr_n_o,
  output logic perr_n_oe,
  input wire logic serr_n_i,
  input wire logic lock_n_i,
  input wire logic own_lock,
  output logic lock_n_o,
  output logic lock_n_oe,
  input wire logic pme_n_i,
  output logic pme_n_o,
  output logic pme_n_oe,
  input wire logic [2:0] sleep_state,
  output pcisb_pkg::pcisb_irq_t irq
);

  // ==========================================================
  // Declarations
  pcisb_pkg::pcisb_ctrl_t ctrl_r;
  logic [pcisb_pkg::STICKY_W-1:0] sticky_r;
  logic [pcisb_pkg::STICKY_W-1:0] sticky_set;
  logic [pcisb_pkg::STICKY_W-1:0] sticky_clr;
  logic [pcisb_pkg::STICKY_W-1:0] sticky_nxt;
  logic strap_r;
  logic pgood_d_r;
  logic lock_seen_r;
  logic [pcisb_pkg::NMASTERS-1:0] arb_req;
  logic [pcisb_pkg::NMASTERS-1:0] arb_gnt;
  logic [pcisb_pkg::NMASTERS-1:0] gnt_n_nxt;
  logic [pcisb_pkg::NMASTERS-1:0] in_mask;
  logic [2:0] in_val;
  logic par_err;
  logic perr_ext;
  logic gen_par;
  logic drive_d_r;
  logic perr_any;
  logic serr_hit;
  logic pme_hit;
  logic in_s0;
  logic in_sleep;
  logic bus_ext;
  logic setup_ph;
  logic wr_acc;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_gpin;
  logic [31:0] rd_mux;
  logic [31:0] stat_word;
  pcisb_pkg::pcisb_irq_t irq_nxt;

  // ==========================================================
  // Sub-blocks
  pcisb_parity u_parity (
    .pclk(pclk),
    .presetn(presetn),
    .ad_i(ad_i),
    .cbe_n_i(cbe_n_i),
    .par_i(par_i),
    .chk_en(tgt_write_phase),
    .gen_par_r(gen_par),
    .err_r(par_err)
  );

  pcisb_arbiter u_arb (
    .pclk(pclk),
    .presetn(presetn),
    .req(arb_req),
    .gnt_r(arb_gnt)
  );

  // ==========================================================
  // Arbitration and general-purpose pin muxing
  // Master four cannot see a grant while its pin is an output, so it would hog the bus
  assign in_mask = {ctrl_r.req_in[2:1], ctrl_r.req_in[0] || ctrl_r.gnt4_out, 4'h0};
  assign arb_req = ~req_n & ~in_mask;
  assign in_val = ~req_n[pcisb_pkg::NMASTERS-1:pcisb_pkg::ALT_IN_FIRST];
  assign bus_ext = |arb_gnt;

  always_comb begin
    gnt_n_nxt = ~arb_gnt;
    if (ctrl_r.gnt4_out) begin
      gnt_n_nxt[pcisb_pkg::ALT_OUT_MASTER] = ctrl_r.out_val;
    end
  end

  // ==========================================================
  // Event decode
  // Our own drive of the error line is not an outside report
  assign perr_ext = !perr_n_i && !perr_n_oe;
  assign perr_any = par_err || perr_ext;
  assign serr_hit = !serr_n_i;
  assign pme_hit = !pme_n_i;
  assign in_s0 = (sleep_state == pcisb_pkg::SLEEP_S0);
  assign in_sleep = !in_s0 && (sleep_state <= pcisb_pkg::SLEEP_S5);

  always_comb begin
    irq_nxt = '0;
    irq_nxt.nmi = perr_any && !ctrl_r.perr_mgmt;
    irq_nxt.mgmt = perr_any && ctrl_r.perr_mgmt;
    if (serr_hit) begin
      case (ctrl_r.serr_route)
        pcisb_pkg::PCISB_ROUTE_NMI: irq_nxt.nmi = 1'b1;
        pcisb_pkg::PCISB_ROUTE_MGMT: irq_nxt.mgmt = 1'b1;
        default: irq_nxt.intr = 1'b1;
      endcase
    end
    irq_nxt.sysctl = pme_hit && in_s0 && ctrl_r.pme_ctl_en;
    irq_nxt.wake = pme_hit && in_sleep;
  end

  // ==========================================================
  // APB decode
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite;
  assign sel_ctrl = (paddr == pcisb_pkg::OFS_CTRL);
  assign sel_stat = (paddr == pcisb_pkg::OFS_STAT);
  assign sel_gpin = (paddr == pcisb_pkg::OFS_GPIN);

  assign stat_word = {17'h00000, ~gnt_n, 2'h0, strap_r, lock_seen_r, sticky_r};

  assign rd_mux = sel_ctrl ? {21'h000000, ctrl_r} :
                  sel_stat ? stat_word :
                  sel_gpin ? {29'h00000000, in_val} : 32'h00000000;

  // Set wins over a write-one clear in the same cycle
  assign sticky_set = {pme_hit, serr_hit, perr_ext, par_err};
  assign sticky_clr = (wr_acc && sel_stat) ? pwdata[pcisb_pkg::STICKY_W-1:0] : '0;
  assign sticky_nxt = (sticky_r & ~sticky_clr) | sticky_set;

  // ==========================================================
  // APB slave: ready in the access phase, one wait-free answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !(sel_ctrl || sel_stat || sel_gpin);
      if (setup_ph) begin
        prdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= pcisb_pkg::CTRL_RESET;
      sticky_r <= '0;
    end else begin
      sticky_r <= sticky_nxt;
      if (wr_acc && sel_ctrl) begin
        ctrl_r <= pcisb_pkg::pcisb_ctrl_t'(pwdata[$bits(pcisb_pkg::pcisb_ctrl_t)-1:0]);
      end
    end
  end

  // ==========================================================
  // Pins, strap and sideband outputs, all on the bus clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gnt_n <= '1;
      pgood_d_r <= 1'b0;
      strap_r <= 1'b0;
      secondary_bus_reset_n <= 1'b0;
      par_o <= 1'b0;
      par_oe <= 1'b0;
      drive_d_r <= 1'b0;
      perr_n_o <= 1'b0;
      perr_n_oe <= 1'b0;
      lock_n_o <= 1'b0;
      lock_n_oe <= 1'b0;
      lock_seen_r <= 1'b0;
      pme_n_o <= 1'b0;
      pme_n_oe <= 1'b0;
      irq <= '0;
    end else begin
      gnt_n <= gnt_n_nxt;
      pgood_d_r <= power_good;
      if (power_good && !pgood_d_r) begin
        strap_r <= gnt6_pin_i;
      end
      secondary_bus_reset_n <= platform_reset_n && !ctrl_r.sec_bus_rst;
      drive_d_r <= drive_phase;
      par_o <= gen_par;
      par_oe <= drive_d_r;
      perr_n_o <= 1'b0;
      perr_n_oe <= par_err;
      lock_n_o <= 1'b0;
      lock_n_oe <= own_lock && !bus_ext;
      lock_seen_r <= !lock_n_i && !bus_ext;
      pme_n_o <= 1'b0;
      pme_n_oe <= ctrl_r.wake_int;
      irq <= irq_nxt;
    end
  end

  // ==========================================================
  // Checks
  property p_perr_drive;
    @(posedge pclk) disable iff (!presetn) par_err |=> (perr_n_oe && !perr_n_o);
  endproperty
  a_perr_drive: assert property (p_perr_drive) else $error("parity error not driven");

  property p_perr_irq;
    @(posedge pclk) disable iff (!presetn) perr_any |=> (irq.nmi || irq.mgmt);
  endproperty
  a_perr_irq: assert property (p_perr_irq) else $error("parity error without NMI or management irq");

  property p_serr_irq;
    @(posedge pclk) disable iff (!presetn) serr_hit |=> (irq.nmi || irq.mgmt || irq.intr);
  endproperty
  a_serr_irq: assert property (p_serr_irq) else $error("system error not signalled");

  // Arbiter and grant register each cost one clock; the mask is combinational
  property p_input_nogrant;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r.req_in[0] [*3] |-> gnt_n[pcisb_pkg::ALT_IN_FIRST] || ctrl_r.gnt4_out;
  endproperty
  a_input_nogrant: assert property (p_input_nogrant) else $error("input-mode request granted");

  property p_alt_out;
    @(posedge pclk) disable iff (!presetn)
      ctrl_r.gnt4_out |=> (gnt_n[pcisb_pkg::ALT_OUT_MASTER] == $past(ctrl_r.out_val));
  endproperty
  a_alt_out: assert property (p_alt_out) else $error("general output wrong");

  property p_strap;
    @(posedge pclk) disable iff (!presetn)
      (power_good && !pgood_d_r) |=> (strap_r == $past(gnt6_pin_i));
  endproperty
  a_strap: assert property (p_strap) else $error("strap not latched");

  // First edge after release still shows the reset value
  property p_secrst;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> secondary_bus_reset_n == ($past(platform_reset_n) && !$past(ctrl_r.sec_bus_rst));
  endproperty
  a_secrst: assert property (p_secrst) else $error("secondary reset wrong");

  property p_lock;
    @(posedge pclk) disable iff (!presetn) bus_ext |=> !lock_seen_r && !lock_n_oe;
  endproperty
  a_lock: assert property (p_lock) else $error("lock honoured under external grant");

  property p_pme;
    @(posedge pclk) disable iff (!presetn) pme_n_oe |-> !pme_n_o;
  endproperty
  a_pme: assert property (p_pme) else $error("wake line driven high");

  property p_wake;
    @(posedge pclk) disable iff (!presetn) (pme_hit && in_sleep) |=> irq.wake;
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");

  property p_sysctl;
    @(posedge pclk) disable iff (!presetn)
      irq.sysctl |-> $past(pme_hit) && $past(in_s0) && $past(ctrl_r.pme_ctl_en);
  endproperty
  a_sysctl: assert property (p_sysctl) else $error("unexpected control interrupt");

  c_perr: cover property (@(posedge pclk) disable iff (!presetn) par_err ##1 perr_n_oe);
  c_wake: cover property (@(posedge pclk) disable iff (!presetn) irq.wake);
  c_sysctl: cover property (@(posedge pclk) disable iff (!presetn) irq.sysctl);
  c_lock: cover property (@(posedge pclk) disable iff (!presetn) lock_n_oe);

endmodule

// File: design/pcisb_pkg.sv
// Shared constants, types and helpers for the PCI sideband control block
package pcisb_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_GPIN = 8'h08;

  // ==========================================================
  // Status field positions
  localparam int ST_PERR_INT = 0;
  localparam int ST_PERR_EXT = 1;
  localparam int ST_SERR = 2;
  localparam int ST_PME = 3;
  localparam int ST_LOCK = 4;
  localparam int ST_STRAP = 5;
  localparam int ST_GNT_LSB = 8;
  localparam int STICKY_W = 4;

  // ==========================================================
  // Bus widths and limits
  localparam int NMASTERS = 7;
  localparam int AD_W = 32;
  localparam int CBE_W = 4;
  localparam int GNT_IDX_W = 3;
  localparam int ALT_IN_FIRST = 4;
  localparam int ALT_OUT_MASTER = 4;
  localparam int STRAP_MASTER = 6;
  localparam logic [2:0] SLEEP_S0 = 3'h0;
  localparam logic [2:0] SLEEP_S5 = 3'h5;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PCISB_ROUTE_NMI = 2'b00,
    PCISB_ROUTE_MGMT = 2'b01,
    PCISB_ROUTE_INT = 2'b10
  } pcisb_route_t;

  typedef struct packed {
    logic wake_int;
    pcisb_route_t serr_route;
    logic perr_mgmt;
    logic pme_ctl_en;
    logic out_val;
    logic gnt4_out;
    logic [2:0] req_in;
    logic sec_bus_rst;
  } pcisb_ctrl_t;

  localparam pcisb_ctrl_t CTRL_RESET = '0;

  typedef struct packed {
    logic nmi;
    logic mgmt;
    logic intr;
    logic sysctl;
    logic wake;
  } pcisb_irq_t;

  // ==========================================================
  // Helpers
  function automatic logic even_par(input logic [AD_W-1:0] ad, input logic [CBE_W-1:0] cbe);
    even_par = ^{ad, cbe};
  endfunction

  function automatic logic [GNT_IDX_W-1:0] rr_pick(input logic [NMASTERS-1:0] req,
                                                   input logic [GNT_IDX_W-1:0] last);
    logic found;
    int idx;
    rr_pick = last;
    found = 1'b0;
    for (int i = 1; i <= NMASTERS; i++) begin
      idx = (int'(last) + i) % NMASTERS;
      if (!found && req[idx]) begin
        found = 1'b1;
        rr_pick = GNT_IDX_W'(idx);
      end
    end
  endfunction

endpackage

// File: design/pcisb_parity.sv
// Even parity generation and target write parity check
module pcisb_parity (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pcisb_pkg::AD_W-1:0] ad_i,
  input wire logic [pcisb_pkg::CBE_W-1:0] cbe_n_i,
  input wire logic par_i,
  input wire logic chk_en,
  output logic gen_par_r,
  output logic err_r
);

  logic chk_en_d_r;

  // ==========================================================
  // Parity lags its phase by one clock, so compare one clock late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_par_r <= 1'b0;
      chk_en_d_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      gen_par_r <= pcisb_pkg::even_par(ad_i, cbe_n_i);
      chk_en_d_r <= chk_en;
      err_r <= chk_en_d_r && (gen_par_r != par_i);
    end
  end

  property p_par_check;
    @(posedge pclk) disable iff (!presetn)
      (chk_en ##1 (par_i != pcisb_pkg::even_par($past(ad_i), $past(cbe_n_i)))) |=> err_r;
  endproperty
  a_par_check: assert property (p_par_check) else $error("parity error missed");

  property p_par_noerr;
    @(posedge pclk) disable iff (!presetn)
      !chk_en_d_r |=> !err_r;
  endproperty
  a_par_noerr: assert property (p_par_noerr) else $error("parity error without check");

endmodule

// File: design/pcisb_arbiter.sv
// Round-robin bus arbiter for the request and grant lines
module pcisb_arbiter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pcisb_pkg::NMASTERS-1:0] req,
  output logic [pcisb_pkg::NMASTERS-1:0] gnt_r
);

  logic [pcisb_pkg::GNT_IDX_W-1:0] last_r;
  logic [pcisb_pkg::GNT_IDX_W-1:0] pick;
  logic hold;
  logic any_req;
  logic [pcisb_pkg::NMASTERS-1:0] gnt_nxt;

  // ==========================================================
  // Selection: keep the owner while it still requests
  assign hold = |(gnt_r & req);
  assign any_req = |req;
  assign pick = pcisb_pkg::rr_pick(req, last_r);
  assign gnt_nxt = hold ? gnt_r : (any_req ? (pcisb_pkg::NMASTERS)'(1) << pick : '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gnt_r <= '0;
      last_r <= '0;
    end else begin
      gnt_r <= gnt_nxt;
      if (!hold && any_req) begin
        last_r <= pick;
      end
    end
  end

  property p_onehot;
    @(posedge pclk) disable iff (!presetn) $onehot0(gnt_r);
  endproperty
  a_onehot: assert property (p_onehot) else $error("more than one grant");

  property p_grant_req;
    @(posedge pclk) disable iff (!presetn) (gnt_r != '0) |-> (|(gnt_r & $past(req)));
  endproperty
  a_grant_req: assert property (p_grant_req) else $error("grant without request");

  c_handover: cover property (@(posedge pclk) disable iff (!presetn)
    (gnt_r != '0) ##1 ((gnt_r != '0) && (gnt_r != $past(gnt_r))));

endmodule

// File: tb/pcisb_peer.sv
// Far-side model: bus masters and agents on the shared sideband wires
module pcisb_peer (
  input wire logic pclk,
  input wire logic [6:0] want,
  input wire logic [6:0] gnt_n,
  input wire logic perr_pulse,
  input wire logic serr_pulse,
  input wire logic pme_req,
  input wire logic perr_n_o,
  input wire logic perr_n_oe,
  input wire logic lock_n_o,
  input wire logic lock_n_oe,
  input wire logic pme_n_o,
  input wire logic pme_n_oe,
  output logic [6:0] req_n,
  output logic perr_n,
  output logic serr_n,
  output logic pme_n,
  output logic lock_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0] done_r = 7'h00;
  logic [2:0] cnt_r [7] = '{default: 3'h0};
  // ==========================================
  // Masters
  // Each master gives the bus up after four granted cycles, so others get a turn
  always @(posedge pclk) begin
    for (int i = 0; i < 7; i++) begin
      if (!want[i]) begin
        done_r[i] <= 1'b0;
        cnt_r[i] <= 3'h0;
      end else if (gnt_n[i] == 1'b0 && !done_r[i]) begin
        cnt_r[i] <= cnt_r[i] + 3'h1;
        done_r[i] <= (cnt_r[i] == 3'h3);
      end
    end
  end
  assign req_n = ~(want & ~done_r);
  // ==========================================
  // Shared lines, pulled up when released
  assign perr_n = ~((perr_n_oe & ~perr_n_o) | perr_pulse);
  assign serr_n = ~serr_pulse;
  assign pme_n = ~((pme_n_oe & ~pme_n_o) | pme_req);
  assign lock_n = ~(lock_n_oe & ~lock_n_o);
endmodule

// File: tb/pci_sideband_control_test.sv
// Self-checking bench for the PCI sideband control block
module pci_sideband_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // Signals
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, ad_i = 32'h0;
  logic pready, pslverr, par_i = 1'b0, tgt_write_phase = 1'b0, drive_phase = 1'b0;
  logic gnt6_pin_i = 1'b0, power_good = 1'b0, platform_reset_n = 1'b1, own_lock = 1'b0;
  logic [3:0] cbe_n_i = 4'h0;
  logic [2:0] sleep_state = 3'h0;
  logic [6:0] want = 7'h00, req_n, gnt_n, g;
  logic perr_pulse = 1'b0, serr_pulse = 1'b0, pme_req = 1'b0;
  logic secondary_bus_reset_n, par_o, par_oe, perr_n, serr_n, lock_n, pme_n;
  logic perr_n_o, perr_n_oe, lock_n_o, lock_n_oe, pme_n_o, pme_n_oe;
  pcisb_pkg::pcisb_irq_t irq;
  logic [32:0] expq[$];
  logic [7:0] acc;
  int failures = 0, n_tests = 0, bad;

  always #5 pclk = ~pclk;

  pcisb_top dut_u (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .req_n(req_n), .gnt_n(gnt_n), .gnt6_pin_i(gnt6_pin_i), .power_good(power_good),
    .platform_reset_n(platform_reset_n), .secondary_bus_reset_n(secondary_bus_reset_n),
    .ad_i(ad_i), .cbe_n_i(cbe_n_i), .par_i(par_i), .tgt_write_phase(tgt_write_phase),
    .drive_phase(drive_phase), .par_o(par_o), .par_oe(par_oe), .perr_n_i(perr_n),
    .perr_n_o(perr_n_o), .perr_n_oe(perr_n_oe), .serr_n_i(serr_n), .lock_n_i(lock_n),
    .own_lock(own_lock), .lock_n_o(lock_n_o), .lock_n_oe(lock_n_oe), .pme_n_i(pme_n),
    .pme_n_o(pme_n_o), .pme_n_oe(pme_n_oe), .sleep_state(sleep_state), .irq(irq)
  );

  pcisb_peer peer_u (
    .pclk(pclk), .want(want), .gnt_n(gnt_n), .perr_pulse(perr_pulse), .serr_pulse(serr_pulse),
    .pme_req(pme_req), .perr_n_o(perr_n_o), .perr_n_oe(perr_n_oe), .lock_n_o(lock_n_o),
    .lock_n_oe(lock_n_oe), .pme_n_o(pme_n_o), .pme_n_oe(pme_n_oe), .req_n(req_n),
    .perr_n(perr_n), .serr_n(serr_n), .pme_n(pme_n), .lock_n(lock_n)
  );

  // ==========================================
  // Helpers
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Idle cycle first, so a release never meets the next setup in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    expq.push_back(exp);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Collects short pulses: {perr drive, pme oe, lock oe, nmi, mgmt, intr, sysctl, wake}
  task automatic catch(input int n);
    acc = 8'h00;
    repeat (n) begin
      @(posedge pclk);
      acc = acc | {perr_n_oe & ~perr_n_o, pme_n_oe, lock_n_oe, irq};
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Read data is judged where the access completes
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      check("read", {pslverr, prdata}, expq.pop_front());

  initial begin
    #100us;
    failures++;
    print_verdict();
  end

  // ==========================================
  // Tests
  initial begin
    void'($urandom(47));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(pcisb_pkg::OFS_CTRL, 33'h0);
    rd(8'h0C, 33'h1_0000_0000);
    for (int v = 0; v < 3; v++) begin
      wr(pcisb_pkg::OFS_CTRL, v == 0 ? 32'h1 : 32'h0);
      platform_reset_n <= (v != 2);
      tick(3);
      check("sec reset", secondary_bus_reset_n, v == 1);
    end
    platform_reset_n <= 1'b1;
    gnt6_pin_i <= 1'b1;
    power_good <= 1'b1;
    tick(3);
    gnt6_pin_i <= 1'b0;
    rd(pcisb_pkg::OFS_STAT, 33'h20);
    $display("test regs done");
    for (int k = 0; k < 6; k++) begin
      wr(pcisb_pkg::OFS_CTRL, k[0] ? 32'hE : 32'h0);
      want <= 7'($urandom());
      bad = 0;
      g = 7'h00;
      repeat (90) begin
        @(posedge pclk);
        g = g | ~gnt_n;
        bad += int'($countones(~gnt_n) > 1);
      end
      check("grants", g, want & (k[0] ? 7'h0F : 7'h7F));
      check("one grant", bad, 0);
      if (k[0])
        rd(pcisb_pkg::OFS_GPIN, {30'h0, want[6:4]});
      want <= 7'h00;
      tick(8);
    end
    for (int v = 0; v < 2; v++) begin
      wr(pcisb_pkg::OFS_CTRL, 32'h10 | (v << 5));
      tick(3);
      check("grant4 out", gnt_n[4], v[0]);
    end
    $display("test arbiter done");
    // Bad parity, good parity, then an outside report
    for (int s = 0; s < 2; s++) begin
      wr(pcisb_pkg::OFS_CTRL, s[0] ? 32'h80 : 32'h0);
      for (int e = 0; e < 3; e++) begin
        ad_i <= $urandom();
        cbe_n_i <= 4'($urandom());
        tgt_write_phase <= (e < 2);
        tick(1);
        tgt_write_phase <= 1'b0;
        par_i <= ^{ad_i, cbe_n_i} ^ (e == 0);
        perr_pulse <= (e == 2);
        tick(1);
        perr_pulse <= 1'b0;
        catch(5);
        check("perr out", acc[7], e == 0);
        check("perr irq", acc[4:3], e == 1 ? 2'b00 : {~s[0], s[0]});
      end
    end
    drive_phase <= 1'b1;
    tick(4);
    check("par out", {par_oe, par_o}, {1'b1, ^{ad_i, cbe_n_i}});
    drive_phase <= 1'b0;
    $display("test parity done");
    for (int r = 0; r < 4; r++) begin
      wr(pcisb_pkg::OFS_CTRL, r << 8);
      serr_pulse <= 1'b1;
      tick(1);
      serr_pulse <= 1'b0;
      catch(4);
      check("serr irq", acc[4:2], r == 0 ? 3'b100 : r == 1 ? 3'b010 : 3'b001);
    end
    rd(pcisb_pkg::OFS_STAT, 33'h27);
    wr(pcisb_pkg::OFS_STAT, 32'h7);
    rd(pcisb_pkg::OFS_STAT, 33'h20);
    // Case six is S0 with the control interrupt left off
    for (int st = 0; st < 7; st++) begin
      sleep_state <= (st == 6) ? 3'h0 : 3'(st);
      wr(pcisb_pkg::OFS_CTRL, st == 0 ? 32'h40 : 32'h0);
      pme_req <= 1'b1;
      catch(4);
      pme_req <= 1'b0;
      check("wake irq", acc[1:0], st == 0 ? 2'b10 : st == 6 ? 2'b00 : 2'b01);
      tick(3);
    end
    sleep_state <= 3'h0;
    wr(pcisb_pkg::OFS_CTRL, 32'h400);
    catch(3);
    check("pme drive", {acc[6], pme_n_o, pme_n}, 3'b100);
    wr(pcisb_pkg::OFS_CTRL, 32'h0);
    own_lock <= 1'b1;
    catch(3);
    check("lock own", {acc[5], lock_n_o}, 2'b10);
    rd(pcisb_pkg::OFS_STAT, 33'h38);
    want <= 7'h01;
    for (bad = 0; bad < 20 && gnt_n[0] !== 1'b0; bad++)
      tick(1);
    tick(2);
    check("lock granted", lock_n_oe, 1'b0);
    own_lock <= 1'b0;
    want <= 7'h00;
    $display("test events done");
    print_verdict();
  end
endmodule
